// *** include/gst_pkg.sv ***
// Package of constants and types for the gated sixteen bit timer.
//
// Notes on behaviour
// - Sixteen bit up-count in two bytes; a byte write updates the count at once.
// - Timer off never counts; on without gate always counts; on with gate follows gate.
// - Clock source 11 slow oscillator, 10 external pin, 01 system, 00 instruction clock.
// - Instruction clock at 1:1 advances the count once per instruction cycle.
// - System clock source advances the count by four per instruction cycle.
// - External pin counts on rising edges, synchronised or not, when counting is allowed.
// - External mode needs a falling edge before the first counted rising edge.
// - Prescaler divides by 1, 2, 4 or 8; its counter is hidden from software.
// - A write to either count byte clears the prescale counter.
// - Sync disable bypasses the synchroniser on the external clock.
// - Asynchronous external counting keeps running in sleep; overflow can wake the core.
// - Switching sync mode may lose or add one increment; this is tolerated.
// - Count bytes read back valid values while running from the external clock.
// - Gate enable bit turns gating on; polarity bit picks active high or low.
// - Active gate lets the count advance on count strobes; inactive gate holds it.
// - Polarity 0 counts while gate is 0; polarity 1 counts while gate is 1.
// - Gate source select 0 picks the gate input pin.
// - Gate source select 1 uses the other timer overflow pulse as gate.
// - Rollover from ffff to 0000 sets the overflow flag; only software clears it.
// - Clearing timer on stops counting and clears the gate toggle flip-flop.
`default_nettype none

package gst_pkg;

    // ************************************************************
    // Register map, byte addresses on APB
    // ************************************************************
    localparam logic [7:0] GST_TIMER_CONTROL_OFS = 8'h00;
    localparam logic [7:0] GST_GATE_CONTROL_OFS = 8'h04;
    localparam logic [7:0] GST_COUNT_LOW_OFS = 8'h08;
    localparam logic [7:0] GST_COUNT_HIGH_OFS = 8'h0c;
    localparam logic [7:0] GST_STATUS_OFS = 8'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int GST_STATUS_OVF_BIT = 0;
    localparam logic [7:0] GST_TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] GST_GATE_CONTROL_RST = 8'h00;
    localparam logic [15:0] GST_COUNT_RST = 16'h0000;
    localparam logic [15:0] GST_COUNT_MAX = 16'hffff;

    // ************************************************************
    // Timing counts
    // ************************************************************
    // The instruction clock runs at a quarter of pclk.
    localparam logic [1:0] GST_INSTR_LAST = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0]
    {
        GST_SRC_INSTR = 2'b00,
        GST_SRC_SYS = 2'b01,
        GST_SRC_EXT = 2'b10,
        GST_SRC_LFOSC = 2'b11
    } gst_src_t;

    // Timer control register, bit 7 down to bit 0.
    typedef struct packed
    {
        gst_src_t clock_source_field;
        logic [1:0] prescale_field;
        logic unused3;
        logic sync_disable_bit;
        logic unused1;
        logic timer_on_bit;
    } gst_ctrl_t;

    // Gate control register, bit 7 down to bit 0.
    typedef struct packed
    {
        logic gate_enable_bit;
        logic gate_polarity_bit;
        logic gate_toggle_bit;
        logic [1:0] unused4;
        logic gate_value;
        logic unused1;
        logic gate_source_select;
    } gst_gate_t;

endpackage : gst_pkg

`default_nettype wire

// *** logic/gst_edge.sv ***
// Edge detector with an optional two-stage synchroniser in front of it.
`default_nettype none

module gst_edge
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw level and bypass control.
    input wire logic d_i,
    input wire logic bypass_i,
    // Level and edges as seen by the timer.
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);

    logic s1_r;
    logic s2_r;
    logic raw_r;
    logic prev_r;

    // The first stage feeds only the second; the bypass path keeps a flop of its own.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            raw_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            raw_r <= d_i;
            prev_r <= lvl_o;
        end
    end

    // A bypass change may make one spurious edge, which the timer tolerates.
    assign lvl_o = bypass_i ? raw_r : s2_r;
    assign rise_o = lvl_o & ~prev_r;
    assign fall_o = ~lvl_o & prev_r;

endmodule : gst_edge

`default_nettype wire

// *** logic/gst_timer.sv ***
// Gated sixteen bit timer with APB register access.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`default_nettype none

module gst_timer
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count clock and gate sources.
    input wire logic external_clock_pin,
    input wire logic low_freq_internal_osc,
    input wire logic gate_input_pin,
    input wire logic other_timer_overflow,
    // Core power state.
    input wire logic sleep_i,
    // Overflow flag towards the core interrupt and wake logic.
    output logic overflow_flag
);
    import gst_pkg::*;

    // ************************************************************
    // Registers and wires
    // ************************************************************
    gst_ctrl_t ctrl_r;
    gst_gate_t gate_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [2:0] pre_cnt_r;
    logic [1:0] instr_cnt_r;
    logic armed_r;
    logic tgl_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ovf_r;

    logic setup;
    logic wr_acc;
    logic sel_ctrl;
    logic sel_gate;
    logic sel_low;
    logic sel_high;
    logic sel_stat;
    logic mapped;
    logic [31:0] rd_mux;
    logic cnt_wr;
    logic ovf_clr;
    logic ext_sel;
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic lf_rise;
    logic gpin_lvl;
    logic instr_en;
    logic run_ok;
    logic src_tick;
    logic [2:0] pre_mask;
    logic pre_strobe;
    logic gate_src;
    logic gate_src_d_r;
    logic gate_val;
    logic gate_active;
    logic count_en;
    logic cnt_inc;
    logic arm_clr;

    // ************************************************************
    // APB decode
    // ************************************************************
    // Every access takes the single access cycle; pready is set during setup.
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_r & pwrite;
    assign sel_ctrl = (paddr == GST_TIMER_CONTROL_OFS);
    assign sel_gate = (paddr == GST_GATE_CONTROL_OFS);
    assign sel_low = (paddr == GST_COUNT_LOW_OFS);
    assign sel_high = (paddr == GST_COUNT_HIGH_OFS);
    assign sel_stat = (paddr == GST_STATUS_OFS);
    assign mapped = sel_ctrl | sel_gate | sel_low | sel_high | sel_stat;
    assign cnt_wr = wr_acc & (sel_low | sel_high);
    assign ovf_clr = wr_acc & sel_stat & pwdata[GST_STATUS_OVF_BIT];

    // Read mux; the count is a pclk register, so a read is always coherent.
    assign rd_mux = sel_ctrl ? {24'h000000, ctrl_r & 8'hf5} :
                    sel_gate ? {24'h000000, gate_r.gate_enable_bit, gate_r.gate_polarity_bit,
                                gate_r.gate_toggle_bit, 2'b00, gate_val, 1'b0, gate_r.gate_source_select} :
                    sel_low ? {24'h000000, count_r[7:0]} :
                    sel_high ? {24'h000000, count_r[15:8]} :
                    sel_stat ? {31'h00000000, ovf_r} :
                    32'h00000000;

    // Bus answer flops; read data is captured at the setup edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup)
            begin
                prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Control register writes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= gst_ctrl_t'(GST_TIMER_CONTROL_RST);
            gate_r <= gst_gate_t'(GST_GATE_CONTROL_RST);
        end
        else
        begin
            if (wr_acc && sel_ctrl)
            begin
                ctrl_r <= gst_ctrl_t'(pwdata[7:0] & 8'hf5);
            end
            if (wr_acc && sel_gate)
            begin
                gate_r <= gst_gate_t'(pwdata[7:0] & 8'he1);
            end
        end
    end

    // ************************************************************
    // Clock sources
    // ************************************************************
    assign ext_sel = (ctrl_r.clock_source_field == GST_SRC_EXT);

    // External clock pin, synchronised unless sync disable is set.
    gst_edge u_ext_edge
    (
        .pclk(pclk),
        .presetn(presetn),
        .d_i(external_clock_pin),
        .bypass_i(ctrl_r.sync_disable_bit),
        .lvl_o(ext_lvl),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // Slow oscillator is always synchronised.
    gst_edge u_lf_edge
    (
        .pclk(pclk),
        .presetn(presetn),
        .d_i(low_freq_internal_osc),
        .bypass_i(1'b0),
        .lvl_o(),
        .rise_o(lf_rise),
        .fall_o()
    );

    // Gate pin shares the sync mode of the external clock.
    gst_edge u_gate_edge
    (
        .pclk(pclk),
        .presetn(presetn),
        .d_i(gate_input_pin),
        .bypass_i(ctrl_r.sync_disable_bit),
        .lvl_o(gpin_lvl),
        .rise_o(),
        .fall_o()
    );

    // Instruction clock enable: one pclk cycle in four.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_cnt_r <= 2'h0;
        end
        else
        begin
            instr_cnt_r <= instr_cnt_r + 2'h1;
        end
    end

    assign instr_en = (instr_cnt_r == GST_INSTR_LAST);

    // Falling edge arming: lost on disable or count write, a falling edge wins over the clear.
    assign arm_clr = ~ctrl_r.timer_on_bit | cnt_wr;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_r <= 1'b0;
        end
        else if (ext_fall)
        begin
            armed_r <= 1'b1;
        end
        else if (arm_clr)
        begin
            armed_r <= 1'b0;
        end
    end

    // Only the asynchronous external clock keeps running in sleep.
    assign run_ok = ~sleep_i | (ext_sel & ctrl_r.sync_disable_bit);

    // Selected count clock as a one-cycle tick.
    always_comb
    begin
        case (ctrl_r.clock_source_field)
            GST_SRC_INSTR: src_tick = instr_en;
            GST_SRC_SYS: src_tick = 1'b1;
            GST_SRC_EXT: src_tick = ext_rise & armed_r;
            GST_SRC_LFOSC: src_tick = lf_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // ************************************************************
    // Prescaler
    // ************************************************************
    assign pre_mask = {ctrl_r.prescale_field == 2'b11, ctrl_r.prescale_field[1], |ctrl_r.prescale_field};
    assign pre_strobe = src_tick & run_ok & ctrl_r.timer_on_bit & ((pre_cnt_r & pre_mask) == pre_mask);

    // Hidden prescale counter; any count byte write restarts it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_cnt_r <= 3'h0;
        end
        else if (cnt_wr || !ctrl_r.timer_on_bit)
        begin
            pre_cnt_r <= 3'h0;
        end
        else if (src_tick && run_ok)
        begin
            pre_cnt_r <= (pre_cnt_r + 3'h1) & pre_mask;
        end
    end

    // ************************************************************
    // Gate
    // ************************************************************
    // Overflow pulse of the other timer is itself the low-to-high gate pulse.
    assign gate_src = gate_r.gate_source_select ? other_timer_overflow : gpin_lvl;

    // Toggle flip-flop, held clear when toggle mode or the timer is off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tgl_r <= 1'b0;
            gate_src_d_r <= 1'b0;
        end
        else
        begin
            gate_src_d_r <= gate_src;
            if (!ctrl_r.timer_on_bit || !gate_r.gate_toggle_bit)
            begin
                tgl_r <= 1'b0;
            end
            else if (gate_src && !gate_src_d_r)
            begin
                tgl_r <= ~tgl_r;
            end
        end
    end

    assign gate_val = gate_r.gate_toggle_bit ? tgl_r : gate_src;
    assign gate_active = (gate_val == gate_r.gate_polarity_bit);
    assign count_en = ctrl_r.timer_on_bit & (~gate_r.gate_enable_bit | gate_active);
    assign cnt_inc = pre_strobe & count_en;

    // ************************************************************
    // Counter and overflow
    // ************************************************************
    // A byte write beats a colliding increment, so a running write may lose one count.
    always_comb
    begin
        count_nxt = count_r;
        if (cnt_inc)
        begin
            count_nxt = count_r + 16'h0001;
        end
        if (wr_acc && sel_low)
        begin
            count_nxt[7:0] = pwdata[7:0];
        end
        if (wr_acc && sel_high)
        begin
            count_nxt[15:8] = pwdata[7:0];
        end
    end

    // Overflow is sticky; a rollover in the clearing cycle keeps the flag set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= GST_COUNT_RST;
            ovf_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            if (cnt_inc && count_r == GST_COUNT_MAX)
            begin
                ovf_r <= 1'b1;
            end
            else if (ovf_clr)
            begin
                ovf_r <= 1'b0;
            end
        end
    end

    assign overflow_flag = ovf_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic run_sys_free;
    logic run_instr_free;
    assign run_sys_free = ctrl_r.timer_on_bit & ~gate_r.gate_enable_bit & ~sleep_i & ~cnt_wr &
                          (ctrl_r.clock_source_field == GST_SRC_SYS) & (ctrl_r.prescale_field == 2'b00);
    assign run_instr_free = ctrl_r.timer_on_bit & ~gate_r.gate_enable_bit & ~sleep_i & ~cnt_wr &
                            (ctrl_r.clock_source_field == GST_SRC_INSTR) & (ctrl_r.prescale_field == 2'b00);

    property p_inc_step;
        @(posedge pclk) disable iff (!presetn)
        (cnt_inc && !cnt_wr) |=> (count_r == $past(count_r) + 16'h0001);
    endproperty
    a_inc_step: assert property (p_inc_step) else $error("Count did not step by one.");

    property p_off_hold;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r.timer_on_bit && !cnt_wr) |=> $stable(count_r);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("Count moved while timer off.");

    property p_sys_four;
        @(posedge pclk) disable iff (!presetn)
        run_sys_free [*4] |=> (count_r == $past(count_r, 4) + 16'h0004);
    endproperty
    a_sys_four: assert property (p_sys_four) else $error("System clock did not add four.");

    property p_instr_one;
        @(posedge pclk) disable iff (!presetn)
        run_instr_free |=> ((count_r - $past(count_r)) == {15'h0000, $past(instr_en)});
    endproperty
    a_instr_one: assert property (p_instr_one) else $error("Instruction clock step wrong.");

    property p_gate_hold;
        @(posedge pclk) disable iff (!presetn)
        (gate_r.gate_enable_bit && !gate_active && !cnt_wr) |=> $stable(count_r);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("Count moved with gate inactive.");

    property p_arm_first;
        @(posedge pclk) disable iff (!presetn)
        (ext_sel && !armed_r && !cnt_wr) |=> $stable(count_r);
    endproperty
    a_arm_first: assert property (p_arm_first) else $error("Counted before a falling edge.");

    property p_pre_clear;
        @(posedge pclk) disable iff (!presetn)
        cnt_wr |=> (pre_cnt_r == 3'h0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("Prescaler kept value after write.");

    property p_ovf_set;
        @(posedge pclk) disable iff (!presetn)
        (cnt_inc && count_r == GST_COUNT_MAX && !cnt_wr) |=> (ovf_r && count_r == GST_COUNT_RST);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("Rollover did not set overflow.");

    property p_ovf_sticky;
        @(posedge pclk) disable iff (!presetn)
        (ovf_r && !ovf_clr) |=> ovf_r;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow flag dropped itself.");

    property p_sleep_stop;
        @(posedge pclk) disable iff (!presetn)
        (sleep_i && !(ext_sel && ctrl_r.sync_disable_bit)) |-> !cnt_inc;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("Counted in sleep while synchronous.");

    property p_tgl_clear;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r.timer_on_bit |=> !tgl_r;
    endproperty
    a_tgl_clear: assert property (p_tgl_clear) else $error("Toggle flop not cleared when off.");

endmodule : gst_timer

`default_nettype wire

// *** test/gst_far_model.sv ***
// Behavioural model of the count clock pins and gate sources around the timer.
`default_nettype none

module gst_far_model
(
    // Clock.
    input wire logic pclk,
    // Controls from the bench.
    input wire logic ext_en,
    input wire logic gate_lvl,
    // Pins towards the timer.
    output logic external_clock_pin,
    output logic low_freq_internal_osc,
    output logic gate_input_pin,
    output logic other_timer_overflow
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] ext_cnt = 3'h0;
    logic [4:0] free_cnt = 5'h0;

    // The pin clock stands still low outside a burst, so each burst opens with a rise.
    always @(posedge pclk)
    begin
        ext_cnt <= ext_en ? ext_cnt + 3'h1 : 3'h0;
        free_cnt <= free_cnt + 5'h1;
    end

    // Pin clock of period 8, slow oscillator of period 32, one wrap pulse per 32 cycles.
    assign external_clock_pin = ext_cnt[2];
    assign low_freq_internal_osc = free_cnt[4];
    assign other_timer_overflow = (free_cnt == 5'h1f);
    assign gate_input_pin = gate_lvl;
endmodule : gst_far_model

`default_nettype wire

// *** test/tb_gated_sixteen_bit_timer.sv ***
// Self-checking testbench of the gated sixteen bit timer.
`default_nettype none

module tb_gated_sixteen_bit_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import gst_pkg::*;

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] gate;
        logic pin;
        logic ext;
        logic slp;
        logic [15:0] exp;
    } gst_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_pin, osc, gate_pin, ovf_in, ovf;
    logic sleep_i = 1'b0;
    logic ext_en = 1'b0;
    logic gate_lvl = 1'b0;
    logic [31:0] r;
    logic e;
    logic [15:0] c;
    int n_fail = 0;
    int checks = 0;

    // Each row runs about 320 cycles; expected counts follow from source and divider.
    gst_row_t rows [18] = '{
        '{8'h41, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0140},
        '{8'h51, 8'h00, 1'b0, 1'b0, 1'b0, 16'h00a0},
        '{8'h61, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0050},
        '{8'h71, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0028},
        '{8'h01, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0050},
        '{8'h31, 8'h00, 1'b0, 1'b0, 1'b0, 16'h000a},
        '{8'h40, 8'h80, 1'b0, 1'b0, 1'b0, 16'h0000},
        '{8'h41, 8'h80, 1'b1, 1'b0, 1'b0, 16'h0000},
        '{8'h41, 8'h80, 1'b0, 1'b0, 1'b0, 16'h0140},
        '{8'h41, 8'hc0, 1'b1, 1'b0, 1'b0, 16'h0140},
        '{8'h41, 8'hc0, 1'b0, 1'b0, 1'b0, 16'h0000},
        '{8'h41, 8'hc1, 1'b0, 1'b0, 1'b0, 16'h000a},
        '{8'h41, 8'he0, 1'b1, 1'b0, 1'b0, 16'h0000},
        '{8'hc1, 8'h00, 1'b0, 1'b0, 1'b0, 16'h000a},
        '{8'h81, 8'h00, 1'b0, 1'b1, 1'b0, 16'h0027},
        '{8'h85, 8'h00, 1'b0, 1'b1, 1'b0, 16'h0027},
        '{8'h41, 8'h00, 1'b0, 1'b0, 1'b1, 16'h0000},
        '{8'h85, 8'h00, 1'b0, 1'b1, 1'b1, 16'h0027}
    };

    gst_timer gst_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_pin(ext_pin), .low_freq_internal_osc(osc),
        .gate_input_pin(gate_pin), .other_timer_overflow(ovf_in), .sleep_i(sleep_i),
        .overflow_flag(ovf));

    gst_far_model gst_far_model_inst (.pclk(pclk), .ext_en(ext_en), .gate_lvl(gate_lvl),
        .external_clock_pin(ext_pin), .low_freq_internal_osc(osc), .gate_input_pin(gate_pin),
        .other_timer_overflow(ovf_in));

    // ************************************************************
    // Clock, closing report and shared tasks
    // ************************************************************
    initial
    begin
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // A tolerance of one absorbs the free-running instruction phase and pin latency.
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp, input int tol);
        checks++;
        if ((^seen) === 1'bx || ((seen > exp) ? seen - exp : exp - seen) > tol)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One APB transfer; an idle edge follows so the next setup never reassigns psel in one step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_cnt();
        apb(1'b0, GST_COUNT_LOW_OFS, 32'h0);
        c[7:0] = r[7:0];
        apb(1'b0, GST_COUNT_HIGH_OFS, 32'h0);
        c[15:8] = r[7:0];
    endtask : rd_cnt

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 20; a += 4)
        begin
            apb(1'b0, a[7:0], 32'h0);
            check("reset value", r[15:0] & 16'hfffb, GST_COUNT_RST, 0);
        end
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped error", {15'h0, e}, 16'h0001, 0);
        check("unmapped data", r[15:0], 16'h0000, 0);
        $display("test reset done");
        for (int i = 0; i < 18; i++)
        begin
            gate_lvl <= rows[i].pin;
            apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h0);
            apb(1'b1, GST_COUNT_LOW_OFS, 32'h0);
            apb(1'b1, GST_COUNT_HIGH_OFS, 32'h0);
            apb(1'b1, GST_GATE_CONTROL_OFS, {24'h0, rows[i].gate});
            sleep_i <= rows[i].slp;
            apb(1'b1, GST_TIMER_CONTROL_OFS, {24'h0, rows[i].ctrl});
            ext_en <= rows[i].ext;
            repeat (317) @(posedge pclk);
            ext_en <= 1'b0;
            apb(1'b1, GST_TIMER_CONTROL_OFS, {24'h0, rows[i].ctrl[7:1], 1'b0});
            sleep_i <= 1'b0;
            rd_cnt();
            check("row count", c, rows[i].exp, 1);
            $display("test row %0d done", i);
        end
        apb(1'b1, GST_GATE_CONTROL_OFS, 32'h0);
        apb(1'b1, GST_COUNT_LOW_OFS, 32'h34);
        apb(1'b1, GST_COUNT_HIGH_OFS, 32'h12);
        rd_cnt();
        check("byte write", c, 16'h1234, 0);
        apb(1'b1, GST_COUNT_LOW_OFS, 32'h0);
        apb(1'b1, GST_COUNT_HIGH_OFS, 32'h0);
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h81);
        for (int p = 0; p < 2; p++)
        begin
            ext_en <= 1'b1;
            repeat (8) @(posedge pclk);
            ext_en <= 1'b0;
            repeat (6) @(posedge pclk);
            rd_cnt();
            check("first pin edges", c, p[15:0], 0);
        end
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h71);
        for (int k = 0; k < 10; k++)
            apb(1'b1, GST_COUNT_LOW_OFS, 32'h0);
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h70);
        rd_cnt();
        check("prescaler clear", c, 16'h0000, 0);
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h40);
        apb(1'b1, GST_COUNT_LOW_OFS, 32'hff);
        apb(1'b1, GST_COUNT_HIGH_OFS, 32'hff);
        check("flag before wrap", {15'h0, ovf}, 16'h0000, 0);
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h41);
        repeat (4) @(posedge pclk);
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h40);
        apb(1'b1, GST_STATUS_OFS, 32'h0);
        apb(1'b0, GST_STATUS_OFS, 32'h0);
        check("flag after wrap", {15'h0, r[GST_STATUS_OVF_BIT]}, 16'h0001, 0);
        apb(1'b1, GST_STATUS_OFS, 32'h1);
        check("flag cleared", {15'h0, ovf}, 16'h0000, 0);
        $display("test hand cases done");
        // A reset in mid-run must clear a running timer and its control register.
        apb(1'b1, GST_TIMER_CONTROL_OFS, 32'h41);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, GST_TIMER_CONTROL_OFS, 32'h0);
        check("control after reset", r[15:0], 16'h0000, 0);
        rd_cnt();
        check("count after reset", c, GST_COUNT_RST, 0);
        check("flag after reset", {15'h0, ovf}, 16'h0000, 0);
        $display("test mid reset done");
        print_verdict();
    end
endmodule : tb_gated_sixteen_bit_timer

`default_nettype wire
